// *** hdl/exception_interrupt_priority.sv ***
// exception event capture and interrupt priority setting logic
// assumes a classic wishbone master, a cpu that pulses accept_i while
// irq_req_o is high, and memory units that pulse fault_i with the address
// sources are level requests already synchronous to clk_i; registers are reached only over wishbone
// every output is registered, so the cpu sees an offer two cycles after a source rises
//
// Chosen here: the Wishbone slave port.

module exception_interrupt_priority (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt sources, one level per slot
  input wire logic [31:0] src_req_i,
  // cpu side
  input wire logic accept_i,
  input wire logic fault_i,
  input wire logic [31:0] fault_addr_i,
  output logic irq_req_o,
  output logic [3:0] irq_level_o,
  output logic [11:0] irq_code_o,
  output logic dispatch_o,
  output logic [1:0] exc_class_o,
  output logic vector_start_o,
  // software interrupt
  output logic irq_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    excp_pkg::core_state_t st;
    logic [7:0][15:0] prio;
    logic [11:0] evt_code;
    logic [31:0] fault_addr;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic irq_req;
    logic [3:0] irq_level;
    logic [11:0] irq_code;
    logic dispatch;
    logic [1:0] exc_class;
    logic vector_start;
  } core_regs_t;

  // every field spelled out so a new state bit cannot slip past reset unnoticed
  localparam core_regs_t CORE_RESET_VAL = '{
    st: excp_pkg::CORE_RESET,
    prio: {excp_pkg::NUM_PRIO{excp_pkg::PRIO_RESET}},
    evt_code: excp_pkg::EVENT_RESET,
    fault_addr: excp_pkg::FAULT_RESET,
    status: '0,
    mask: '0,
    irq: '0,
    irq_req: '0,
    irq_level: excp_pkg::LEVEL_MASKED,
    irq_code: '0,
    dispatch: '0,
    exc_class: excp_pkg::EXC_NONE,
    vector_start: '0
  };

  core_regs_t q;
  core_regs_t d;

  reg_if rbus ();
  prio_if pbus ();

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_word(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_word

  // true when the address falls in the priority register window
  function automatic logic is_prio(input logic [31:0] addr);
    return addr[31:excp_pkg::PRIO_IDX_MSB+1] == excp_pkg::ADDR_PRIO_BASE[31:excp_pkg::PRIO_IDX_MSB+1];
  endfunction : is_prio

  function automatic logic [2:0] prio_idx(input logic [31:0] addr);
    return addr[excp_pkg::PRIO_IDX_MSB:excp_pkg::PRIO_IDX_LSB];
  endfunction : prio_idx

  function automatic logic word_hit(input logic [31:0] addr, input logic [31:0] target);
    return addr[31:excp_pkg::PRIO_IDX_LSB] == target[31:excp_pkg::PRIO_IDX_LSB];
  endfunction : word_hit

  // exception code offered for a slot
  function automatic logic [11:0] slot_code(input logic [4:0] slot);
    logic [11:0] prod;
    prod = 12'(slot) * excp_pkg::CODE_STEP;
    return 12'(excp_pkg::CODE_BASE + prod);
  endfunction : slot_code

  // top bit of field f inside a priority register, fields counted from the top nibble
  function automatic int field_top(input int f);
    return excp_pkg::PRIO_W - 1 - f * excp_pkg::FIELD_W;
  endfunction : field_top

  // flat source slot of field f in priority register r
  function automatic int slot_of(input int r, input int f);
    return r * excp_pkg::FIELDS + f;
  endfunction : slot_of

  // a priority register as a bus word, upper half always zero
  function automatic logic [31:0] prio_word(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : prio_word

  // a two-bit flag register as a bus word
  function automatic logic [31:0] flag_word(input logic [1:0] v);
    return {30'h0000_0000, v};
  endfunction : flag_word

  // sticky flags: an event in the same cycle as its clear survives, so none is lost
  function automatic logic [1:0] sticky_next(input logic [1:0] old_v, input logic [1:0] clr_v,
                                             input logic [1:0] set_v);
    return (old_v & ~clr_v) | set_v;
  endfunction : sticky_next

  // ------------------------------------------------------------------
  // bus front end and arbiter
  // ------------------------------------------------------------------
  wb_reg_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .r(rbus.slave)
  );

  prio_arbiter u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .p(pbus.arb)
  );

  // ------------------------------------------------------------------
  // field unpacking: slot = register * 4 + field, top nibble first
  // ------------------------------------------------------------------
  logic [31:0] slot_used;

  always_comb begin
    slot_used = '0;
    pbus.levels = '0;
    for (int r = 0; r < excp_pkg::NUM_PRIO; r++) begin
      for (int f = 0; f < excp_pkg::FIELDS; f++) begin
        // independent 4-bit fields, mapped in table order
        pbus.levels[slot_of(r, f)] = q.prio[r][field_top(f) -: excp_pkg::FIELD_W];
        slot_used[slot_of(r, f)] = excp_pkg::PRIO_WMASK[r][field_top(f)];
      end
    end
  end

  // level zero is masked and reserved slots never request
  always_comb begin
    pbus.pend = '0;
    for (int s = 0; s < excp_pkg::NUM_SLOTS; s++) begin
      pbus.pend[s] = src_req_i[s] & slot_used[s] & (pbus.levels[s] != excp_pkg::LEVEL_MASKED);
    end
  end

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  logic hit_prio;
  logic hit_event;
  logic hit_fault;
  logic hit_status;
  logic hit_mask;
  logic [2:0] sel_prio;

  // one decode shared by reads and writes, so the two can never disagree on the map
  always_comb begin
    hit_prio = is_prio(rbus.addr);
    hit_event = word_hit(rbus.addr, excp_pkg::ADDR_EVENT);
    hit_fault = word_hit(rbus.addr, excp_pkg::ADDR_FAULT);
    hit_status = word_hit(rbus.addr, excp_pkg::ADDR_STATUS);
    hit_mask = word_hit(rbus.addr, excp_pkg::ADDR_MASK);
    sel_prio = prio_idx(rbus.addr);
  end

  always_comb begin
    rbus.rdata = '0;
    if (hit_prio) begin
      // reserved nibbles are never stored, so they read as zero
      rbus.rdata = prio_word(q.prio[sel_prio]);
    end else if (hit_event) begin
      rbus.rdata = {20'h00000, q.evt_code};
    end else if (hit_fault) begin
      rbus.rdata = q.fault_addr;
    end else if (hit_status) begin
      rbus.rdata = flag_word(q.status);
    end else if (hit_mask) begin
      rbus.rdata = flag_word(q.mask);
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic running;
  logic take_irq;
  logic take_fault;
  logic [31:0] merged;
  logic [1:0] events;
  logic [1:0] clr;

  always_comb begin
    d = q;
    running = (q.st == excp_pkg::CORE_RUN);
    // an accept only counts while a request is actually offered
    take_irq = running & accept_i & q.irq_req;
    take_fault = running & fault_i;
    merged = '0;
    events = '0;
    clr = '0;
    d.dispatch = 1'b0;
    d.vector_start = 1'b0;

    unique case (q.st)
      excp_pkg::CORE_RESET: begin
        // first cycle out of reset starts at the reset vector
        d.st = excp_pkg::CORE_RUN;
        d.vector_start = 1'b1;
      end
      excp_pkg::CORE_RUN: begin
        d.st = excp_pkg::CORE_RUN;
      end
    endcase

    // software writes
    if (rbus.wr) begin
      if (hit_prio) begin
        merged = merge_word(prio_word(q.prio[sel_prio]), rbus.wdata, rbus.sel);
        // reserved fields are dropped on write
        d.prio[sel_prio] = merged[15:0] & excp_pkg::PRIO_WMASK[sel_prio];
      end else if (hit_event) begin
        // read-only: the code moves only when an interrupt is accepted
        d.evt_code = q.evt_code;
      end else if (hit_fault) begin
        d.fault_addr = merge_word(q.fault_addr, rbus.wdata, rbus.sel);
      end else if (hit_status && rbus.sel[0]) begin
        clr = rbus.wdata[1:0];
      end else if (hit_mask && rbus.sel[0]) begin
        d.mask = rbus.wdata[1:0];
      end
    end

    // hardware captures override a same-cycle software write
    if (take_irq) begin
      d.evt_code = q.irq_code;
      events[excp_pkg::STAT_ACCEPT_BIT] = 1'b1;
    end
    if (take_fault) begin
      d.fault_addr = fault_addr_i;
      events[excp_pkg::STAT_FAULT_BIT] = 1'b1;
    end

    // general exceptions take precedence in the class report
    if (take_fault) begin
      d.dispatch = 1'b1;
      d.exc_class = excp_pkg::EXC_GENERAL;
    end else if (take_irq) begin
      d.dispatch = 1'b1;
      d.exc_class = excp_pkg::EXC_INTERRUPT;
    end

    // sticky status: set wins over write-one-to-clear
    d.status = sticky_next(q.status, clr, events);
    d.irq = |(d.status & d.mask);

    // offered request, one cycle behind the arbiter
    d.irq_req = running & pbus.win_valid;
    d.irq_level = pbus.win_valid ? pbus.win_level : excp_pkg::LEVEL_MASKED;
    d.irq_code = slot_code(pbus.win_slot);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= CORE_RESET_VAL;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign irq_req_o = q.irq_req;
  assign irq_level_o = q.irq_level;
  assign irq_code_o = q.irq_code;
  assign dispatch_o = q.dispatch;
  assign exc_class_o = q.exc_class;
  assign vector_start_o = q.vector_start;
  assign irq_o = q.irq;

endmodule : exception_interrupt_priority

// *** hdl/excp_ifs.sv ***
// interfaces between the bus front end, the arbiter and the core
// assumes excp_pkg is compiled first

interface reg_if;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] rdata;
  modport slave (output wr, output addr, output wdata, output sel, input rdata);
  modport core (input wr, input addr, input wdata, input sel, output rdata);
endinterface : reg_if

interface prio_if;
  logic [31:0][3:0] levels;
  logic [31:0] pend;
  logic win_valid;
  logic [4:0] win_slot;
  logic [3:0] win_level;
  modport arb (input levels, input pend, output win_valid, output win_slot, output win_level);
  modport core (output levels, output pend, input win_valid, input win_slot, input win_level);
endinterface : prio_if

// *** hdl/excp_pkg.sv ***
// constants and types shared by the exception and interrupt priority block
// assumes a 32-bit classic wishbone register bus and one 100 MHz clock

package excp_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [31:0] ADDR_FAULT = 32'h0fff_fffc;
  localparam logic [31:0] ADDR_EVENT = 32'ha400_0000;
  localparam logic [31:0] ADDR_PRIO_BASE = 32'ha408_0000;
  localparam logic [31:0] ADDR_STATUS = 32'ha408_0020;
  localparam logic [31:0] ADDR_MASK = 32'ha408_0024;
  // priority registers a..h sit at base + 4 * index, index in these bits
  localparam int PRIO_IDX_LSB = 2;
  localparam int PRIO_IDX_MSB = 4;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int NUM_PRIO = 8;
  localparam int FIELDS = 4;
  localparam int FIELD_W = 4;
  localparam int PRIO_W = 16;
  localparam int NUM_SLOTS = 32;
  localparam int SLOT_W = 5;
  localparam int CODE_W = 12;
  localparam int STAT_W = 2;

  // ------------------------------------------------------------------
  // reset values and field layouts
  // ------------------------------------------------------------------
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [3:0] LEVEL_MASKED = 4'h0;
  // writable nibbles per register, h down to a; zero nibbles are reserved
  localparam logic [7:0][15:0] PRIO_WMASK = {
    16'hff00, 16'hff00, 16'h00f0, 16'hffff,
    16'hffff, 16'hffff, 16'hff00, 16'hffff
  };
  localparam logic [11:0] EVENT_RESET = 12'h000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;

  // exception codes per slot: base + slot * step (values are arbitrary)
  localparam logic [11:0] CODE_BASE = 12'h400;
  localparam logic [11:0] CODE_STEP = 12'h020;

  // status and mask bit positions
  localparam int STAT_ACCEPT_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;

  // exception class output codes
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_GENERAL = 2'h1;
  localparam logic [1:0] EXC_INTERRUPT = 2'h2;

  typedef enum logic [1:0] {
    CORE_RESET = 2'b01,
    CORE_RUN = 2'b10
  } core_state_t;

endpackage : excp_pkg

// *** hdl/prio_arbiter.sv ***
// picks the pending source with the highest level, lower slot wins ties
// assumes pend already excludes masked and reserved slots

module prio_arbiter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels in, winner out
  prio_if.arb p
);

  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [3:0] level;
  } arb_state_t;

  arb_state_t q;
  arb_state_t d;

  assign p.win_valid = q.valid;
  assign p.win_slot = q.slot;
  assign p.win_level = q.level;

  always_comb begin
    d = '0;
    for (int i = 0; i < excp_pkg::NUM_SLOTS; i++) begin
      // strict compare keeps the earlier slot on equal levels
      if (p.pend[i] && (p.levels[i] > d.level)) begin
        d.valid = 1'b1;
        d.slot = 5'(i);
        d.level = p.levels[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : prio_arbiter

// *** hdl/wb_reg_slave.sv ***
// classic wishbone slave front end: one wait state, registered read data
// assumes the master holds the request until it samples ack

module wb_reg_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  reg_if.slave r
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } slave_state_t;

  slave_state_t q;
  slave_state_t d;
  logic req;

  assign req = wb_cyc_i & wb_stb_i;
  assign r.addr = wb_adr_i;
  assign r.wdata = wb_dat_i;
  assign r.sel = wb_sel_i;
  // writes commit on the edge where the master sees ack, not earlier
  assign r.wr = req & wb_we_i & q.ack;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;

  always_comb begin
    d = q;
    d.ack = req & ~q.ack;
    if (req & ~q.ack) begin
      d.dat = r.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : wb_reg_slave

// *** test/exception_interrupt_priority_checker.sv ***
// port-level checks for the priority block
// assumes one clock and a synchronous active-high reset

module exception_interrupt_priority_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sources and cpu side
  input wire logic [31:0] src_req_i,
  input wire logic accept_i,
  input wire logic fault_i,
  input wire logic irq_req_o,
  input wire logic [3:0] irq_level_o,
  input wire logic dispatch_o,
  input wire logic [1:0] exc_class_o,
  input wire logic vector_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer not one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  a_event_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == excp_pkg::ADDR_EVENT
    |-> wb_dat_o[31:12] == 20'h0)
    else $error("event code upper bits not zero");
  a_accept_dispatch: assert property (accept_i && irq_req_o && !fault_i && !$past(rst_i)
    |=> dispatch_o && exc_class_o == excp_pkg::EXC_INTERRUPT)
    else $error("accepted interrupt not dispatched");
  a_fault_dispatch: assert property (fault_i && !$past(rst_i)
    |=> dispatch_o && exc_class_o == excp_pkg::EXC_GENERAL)
    else $error("fault not dispatched as general");
  a_level_masks: assert property (irq_req_o == (irq_level_o != excp_pkg::LEVEL_MASKED))
    else $error("offer and level disagree");
  a_idle_no_offer: assert property ($past(src_req_i) == 32'h0 && $past(src_req_i, 2) == 32'h0
    |-> !irq_req_o)
    else $error("offer without source");
  a_vector_start: assert property ($fell(rst_i) |=> vector_start_o ##1 !vector_start_o)
    else $error("reset vector pulse wrong");
endmodule : exception_interrupt_priority_checker

bind exception_interrupt_priority exception_interrupt_priority_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .src_req_i(src_req_i), .accept_i(accept_i), .fault_i(fault_i), .irq_req_o(irq_req_o),
  .irq_level_o(irq_level_o), .dispatch_o(dispatch_o), .exc_class_o(exc_class_o),
  .vector_start_o(vector_start_o)
);

// *** test/exception_interrupt_priority_tb_top.sv ***
// self-checking bench for the priority block
// assumes excp_pkg and the design files are compiled first

`define chk(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

module exception_interrupt_priority_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fault = 1'b0, cpu_en = 1'b0, accept;
  logic [3:0] sel = 4'h0, cpu_dly = 4'h0, irq_level_o;
  logic [31:0] adr = 32'h0, dat = 32'h0, src = 32'h0, faddr = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_req_o, dispatch_o, vector_start_o, irq_o;
  logic [11:0] irq_code_o;
  logic [1:0] exc_class_o;
  int compares = 0, miscompares = 0;
  // usable nibbles a..h, reserved ones read zero
  localparam logic [15:0] used_m [8] = '{16'hffff, 16'hff00, 16'hffff, 16'hffff,
    16'hffff, 16'h00f0, 16'hff00, 16'hff00};

  always #5 clk_i = ~clk_i;

  exception_interrupt_priority u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_req_i(src), .accept_i(accept), .fault_i(fault), .fault_addr_i(faddr),
    .irq_req_o(irq_req_o), .irq_level_o(irq_level_o), .irq_code_o(irq_code_o),
    .dispatch_o(dispatch_o), .exc_class_o(exc_class_o), .vector_start_o(vector_start_o),
    .irq_o(irq_o)
  );

  excp_cpu_model u_cpu (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(cpu_en), .delay_i(cpu_dly),
    .irq_req_i(irq_req_o), .accept_o(accept)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic end_of_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `chk(q, e)
  endtask : rd_chk

  task automatic wait_disp();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dispatch_o !== 1'b1 && n < 40);
    `chk(dispatch_o, 1'b1)
    if (dispatch_o !== 1'b1) begin
      end_of_test();
    end
  endtask : wait_disp

  // the offer lags a change by two cycles; four leaves margin
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask : settle

  function automatic logic [31:0] pa(input int i);
    return excp_pkg::ADDR_PRIO_BASE + 32'(4 * i);
  endfunction : pa

  function automatic logic [11:0] code_of(input int s);
    return excp_pkg::CODE_BASE + 12'(s) * excp_pkg::CODE_STEP;
  endfunction : code_of

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    // reset vector pulse stands for the one cycle after the first edge out of reset
    repeat (2) @(posedge clk_i);
    `chk(vector_start_o, 1'b1)
    @(posedge clk_i);
    `chk(vector_start_o, 1'b0)
    for (int i = 0; i < 8; i++) begin
      rd_chk(pa(i), 32'h0);
    end
    rd_chk(excp_pkg::ADDR_EVENT, 32'h0);
    rd_chk(excp_pkg::ADDR_FAULT, 32'h0);
    rd_chk(excp_pkg::ADDR_STATUS, 32'h0);
  endtask : t_reset

  task automatic t_regs();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, pa(i), {16'h0, 16'ha5c3 & used_m[i]}, q);
      rd_chk(pa(i), {16'h0, 16'ha5c3 & used_m[i]});
      wb(1'b1, pa(i), 32'h0, q);
    end
    wb(1'b1, excp_pkg::ADDR_EVENT, 32'h0000_0fff, q);
    rd_chk(excp_pkg::ADDR_EVENT, 32'h0);
    wb(1'b1, 32'ha408_0030, 32'hffff_ffff, q);
    rd_chk(32'ha408_0030, 32'h0);
  endtask : t_regs

  task automatic t_fault();
    logic [31:0] q;
    wb(1'b1, excp_pkg::ADDR_FAULT, 32'h1234_5678, q);
    rd_chk(excp_pkg::ADDR_FAULT, 32'h1234_5678);
    @(posedge clk_i);
    fault <= 1'b1;
    faddr <= 32'hdead_beec;
    @(posedge clk_i);
    fault <= 1'b0;
    faddr <= 32'h2152_4113;
    wait_disp();
    `chk(exc_class_o, excp_pkg::EXC_GENERAL)
    rd_chk(excp_pkg::ADDR_FAULT, 32'hdead_beec);
    rd_chk(excp_pkg::ADDR_STATUS, 32'h2);
    settle();
    `chk(irq_o, 1'b0)
    wb(1'b1, excp_pkg::ADDR_MASK, 32'h3, q);
    settle();
    `chk(irq_o, 1'b1)
    wb(1'b1, excp_pkg::ADDR_STATUS, 32'h2, q);
    settle();
    `chk(irq_o, 1'b0)
    rd_chk(excp_pkg::ADDR_STATUS, 32'h0);
  endtask : t_fault

  task automatic t_arb();
    logic [31:0] q;
    wb(1'b1, pa(0), 32'h0000_05f0, q);
    wb(1'b1, pa(2), 32'h0000_3300, q);
    src <= 32'h0000_0001;
    settle();
    `chk(irq_req_o, 1'b0)
    src <= 32'h0000_0300;
    settle();
    `chk(irq_level_o, 4'h3)
    `chk(irq_code_o, code_of(8))
    src <= 32'h0000_0307;
    settle();
    `chk(irq_level_o, 4'hf)
    `chk(irq_code_o, code_of(2))
    cpu_en <= 1'b1;
    wait_disp();
    cpu_en <= 1'b0;
    `chk(exc_class_o, excp_pkg::EXC_INTERRUPT)
    rd_chk(excp_pkg::ADDR_EVENT, {20'h0, code_of(2)});
    `chk(irq_o, 1'b1)
    src <= 32'h0000_0300;
    cpu_dly <= 4'h5;
    settle();
    cpu_en <= 1'b1;
    wait_disp();
    cpu_en <= 1'b0;
    src <= 32'h0;
    rd_chk(excp_pkg::ADDR_EVENT, {20'h0, code_of(8)});
    wb(1'b1, excp_pkg::ADDR_STATUS, 32'h1, q);
    rd_chk(excp_pkg::ADDR_STATUS, 32'h0);
  endtask : t_arb

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_fault();
    t_arb();
    end_of_test();
  end
endmodule : exception_interrupt_priority_tb_top

// *** test/excp_cpu_model.sv ***
// cpu stand-in that takes the offered interrupt after a set delay
// assumes irq_req_i comes straight from the block's offer output

module excp_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control from the bench
  input wire logic en_i,
  input wire logic [3:0] delay_i,
  // offer and answer
  input wire logic irq_req_i,
  output logic accept_o
);
  logic [3:0] cnt_q;
  logic done_q;

  // one accept per enable, so a held source is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      accept_o <= 1'b0;
    end else begin
      accept_o <= 1'b0;
      if (irq_req_i && !done_q) begin
        if (cnt_q == delay_i) begin
          accept_o <= 1'b1;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : excp_cpu_model
